// ### hdl/tlr_pkg.sv
// Constants shared by the three lane serial to parallel receiver.
//
// Contract
// RULE1: Accept three serial data lanes plus a forwarded clock; present 21 outputs.
// RULE2: Each lane carries seven bits per forwarded clock cycle, from a multiplied clock.
// RULE3: Drive a strobe clock output; data are valid on its rising edge.
// RULE4: While sleep_n is low the parallel outputs stay frozen.
// RULE5: Sleep may be asserted at any moment and enters the low-power state.
// RULE6: When the forwarded clock stops, the strobe stops and outputs hold.
// RULE7: The transmitter starts toggling only 10 ms after wake and good supply.
// RULE8: The strobe period follows the forwarded clock, 25 to 50 ns. The code needs frames more than three mclk cycles (60 ns) apart.
// RULE9: Lock takes at most 10 ms; outputs before lock are invalid.
// RULE10: Bit order and lane mapping match the transmitter, framed on the clock edge.
package tlr_pkg;

  localparam int TLR_LANES = 3;
  localparam int TLR_BITS = 7;
  localparam int TLR_WORD_W = TLR_LANES * TLR_BITS;
  localparam int TLR_SLOT_W = 3;

  // Slot indices of the first, next and last bit in a lane cycle, and the unaligned marker.
  localparam logic [2:0] TLR_SLOT_FIRST = 3'h0;
  localparam logic [2:0] TLR_SLOT_NEXT = 3'h1;
  localparam logic [2:0] TLR_SLOT_LAST = 3'h6;
  localparam logic [2:0] TLR_SLOT_IDLE = 3'h7;

  localparam logic [20:0] TLR_DATA_RST = 21'h000000;

  localparam int TLR_MCLK_HZ = 50_000_000;
  localparam int TLR_MCLK_NS = 20;

  // Lock time is a longest time, so the cycle count rounds down.
  localparam int TLR_LOCK_MS = 10;
  localparam int TLR_LOCK_CYC = (TLR_MCLK_HZ / 1000) * TLR_LOCK_MS;

  // Transmitter start-up delay; kept here for the far side's reference.
  localparam int TLR_TX_LOCK_MS = 10;

  localparam int TLR_STROBE_MIN_NS = 25;
  localparam int TLR_STROBE_MAX_NS = 50;

  // Frames missing for this many mclk cycles count as a stopped clock.
  localparam int TLR_LOSS_CYC = 64;

endpackage

// ### hdl/tlr_word_hold.sv
// Holding register for one recovered parallel word.
`timescale 1ns/1ps
module tlr_word_hold #(
  parameter int WIDTH = 21
) (
  input  wire logic             clk,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] word_q;

  // No reset: the word is only read after a write has been flagged.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      word_q <= wr_data;
    end
  end

  assign rd_data = word_q;

endmodule

// ### hdl/tlr_receiver.sv
// Three lane serial to parallel receiver with strobe clock output.
`timescale 1ns/1ps
module tlr_receiver #(
  parameter int LOCK_CYC = tlr_pkg::TLR_LOCK_CYC,
  parameter int LOSS_CYC = tlr_pkg::TLR_LOSS_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        link_clk,
  input  wire logic [2:0]  serial_lane_in,
  input  wire logic        forwarded_clock_in,
  input  wire logic        sleep_n,
  output logic      [20:0] parallel_data_out,
  output logic             strobe_clock_out,
  output logic             link_locked
);

  localparam int LOCK_W = $clog2(LOCK_CYC + 1);
  localparam int LOSS_W = $clog2(LOSS_CYC + 1);
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYC - 1);
  localparam logic [LOSS_W-1:0] LOSS_END = LOSS_W'(LOSS_CYC);

  typedef enum logic [1:0] {
    TLR_SLEEP,
    TLR_HUNT,
    TLR_LOCK,
    TLR_RUN
  } tlr_state_type;

  // Link domain, clocked by the multiplied bit clock.
  logic        lrst_m_q;
  logic        lrst_q;
  logic        lsleep_m_q;
  logic        lsleep_q;
  logic [2:0]  lane_m_q;
  logic [2:0]  lane_q;
  logic        fck_m_q;
  logic        fck_q;
  logic        fck_d1_q;
  logic        fck_rise;
  logic        lhold;
  logic [2:0]  slot_q;
  logic [2:0]  slot_d;
  logic        frame_done;
  logic        done_q;
  logic        commit;
  logic [6:0]  sr_q [3];
  logic [20:0] word_d;
  logic        frm_tgl_q;
  logic [20:0] word_hold;

  // Main clock domain.
  logic          tgl_m_q;
  logic          tgl_s_q;
  logic          tgl_d_q;
  logic          new_frame;
  logic          sleep_m_q;
  logic          sleep_s_q;
  logic          awake;
  logic [LOSS_W-1:0] gap_q;
  logic          lost;
  logic [LOCK_W-1:0] lock_cnt_q;
  tlr_state_type state_q;
  tlr_state_type state_d;
  logic          upd;
  logic          started_q;
  logic [20:0]   data_q;
  logic          strobe_q;
  logic          locked_q;

  // Link-side reset and sleep are levels from the main domain or a pin.
  always_ff @(posedge link_clk) begin
    lrst_m_q <= rst;
    lrst_q   <= lrst_m_q;
  end

  always_ff @(posedge link_clk) begin
    lsleep_m_q <= sleep_n;
    lsleep_q   <= lsleep_m_q;
  end

  // RULE1 lane input sync
  // Lanes and clock pass the same two stages so their alignment is kept.
  always_ff @(posedge link_clk) begin
    lane_m_q <= serial_lane_in;
    lane_q   <= lane_m_q;
    fck_m_q  <= forwarded_clock_in;
    fck_q    <= fck_m_q;
    fck_d1_q <= fck_q;
  end

  // RULE10 frame start edge
  assign fck_rise = fck_q & ~fck_d1_q;

  // RULE5 link sleep hold
  assign lhold = lrst_q | ~lsleep_q;

  // RULE2 seven bit slots
  always_comb begin
    slot_d = slot_q;
    if (fck_rise) begin
      slot_d = tlr_pkg::TLR_SLOT_NEXT;
    end else if (slot_q != tlr_pkg::TLR_SLOT_IDLE) begin
      slot_d = slot_q + 3'h1;
    end
  end

  // A missing edge after the last slot leaves the counter idle, so a
  // stopped forwarded clock produces no further frames.
  always_ff @(posedge link_clk) begin
    if (lhold) begin
      slot_q <= tlr_pkg::TLR_SLOT_IDLE;
    end else begin
      slot_q <= slot_d;
    end
  end

  // RULE6 frames need the clock
  assign frame_done = ~lhold & ~fck_rise & (slot_q == tlr_pkg::TLR_SLOT_LAST);

  // RULE6 word confirmed by next edge
  // A word counts only when the forwarded clock rises straight after its
  // last bit, so a frame cut short by a stopped clock is never delivered.
  always_ff @(posedge link_clk) begin
    if (lhold) begin
      done_q <= 1'b0;
    end else begin
      done_q <= frame_done;
    end
  end

  assign commit = done_q & fck_rise;

  // RULE10 first bit lands low
  genvar gl;
  generate
    for (gl = 0; gl < tlr_pkg::TLR_LANES; gl++) begin : g_lane
      always_ff @(posedge link_clk) begin
        if (lhold) begin
          sr_q[gl] <= 7'h00;
        end else begin
          sr_q[gl] <= {lane_q[gl], sr_q[gl][6:1]};
        end
      end

      assign word_d[gl*7 +: 7] = {lane_q[gl], sr_q[gl][6:1]};
    end
  endgenerate

  tlr_word_hold #(
    .WIDTH (tlr_pkg::TLR_WORD_W)
  ) u_hold (
    .clk     (link_clk),
    .wr_en   (frame_done),
    .wr_data (word_d),
    .rd_data (word_hold)
  );

  // The toggle marks a word; it stays put for seven bit times, which
  // must exceed the three main-clock cycles the crossing needs.
  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      frm_tgl_q <= 1'b0;
    end else if (commit) begin
      frm_tgl_q <= ~frm_tgl_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tgl_m_q <= 1'b0;
      tgl_s_q <= 1'b0;
      tgl_d_q <= 1'b0;
    end else begin
      tgl_m_q <= frm_tgl_q;
      tgl_s_q <= tgl_m_q;
      tgl_d_q <= tgl_s_q;
    end
  end

  assign new_frame = tgl_s_q ^ tgl_d_q;

  // RULE5 sleep pin sync
  always_ff @(posedge mclk) begin
    if (rst) begin
      sleep_m_q <= 1'b0;
      sleep_s_q <= 1'b0;
    end else begin
      sleep_m_q <= sleep_n;
      sleep_s_q <= sleep_m_q;
    end
  end

  assign awake = sleep_s_q;

  // RULE6 stopped clock watch
  always_ff @(posedge mclk) begin
    if (rst || new_frame) begin
      gap_q <= '0;
    end else if (gap_q != LOSS_END) begin
      gap_q <= gap_q + LOSS_W'(1);
    end
  end

  assign lost = (gap_q == LOSS_END);

  // RULE9 lock sequence
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      TLR_SLEEP: begin
        if (awake) begin
          state_d = TLR_HUNT;
        end
      end
      TLR_HUNT: begin
        if (new_frame) begin
          state_d = TLR_LOCK;
        end
      end
      TLR_LOCK: begin
        if (lost) begin
          state_d = TLR_HUNT;
        end else if (lock_cnt_q == LOCK_LAST) begin
          state_d = TLR_RUN;
        end
      end
      TLR_RUN: begin
        if (lost) begin
          state_d = TLR_HUNT;
        end
      end
    endcase
    if (!awake) begin
      state_d = TLR_SLEEP;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= TLR_SLEEP;
    end else begin
      state_q <= state_d;
    end
  end

  // RULE9 lock time count
  always_ff @(posedge mclk) begin
    if (rst || state_q != TLR_LOCK) begin
      lock_cnt_q <= '0;
    end else if (lock_cnt_q != LOCK_LAST) begin
      lock_cnt_q <= lock_cnt_q + LOCK_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= (state_d == TLR_RUN);
    end
  end

  // RULE4 freeze while asleep
  assign upd = new_frame & awake & (state_q == TLR_RUN);

  // RULE1 parallel word out
  always_ff @(posedge mclk) begin
    if (rst) begin
      data_q <= tlr_pkg::TLR_DATA_RST;
    end else if (upd) begin
      data_q <= word_hold;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      started_q <= 1'b0;
    end else if (upd) begin
      started_q <= 1'b1;
    end
  end

  // RULE3 strobe after data
  // RULE8 one strobe per frame
  // The strobe falls with each data change and rises one cycle later, so
  // its period tracks the forwarded clock; it rests high once frames stop, and low before the first word.
  always_ff @(posedge mclk) begin
    if (rst) begin
      strobe_q <= 1'b0;
    end else if (upd) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= started_q;
    end
  end

  assign parallel_data_out = data_q;
  assign strobe_clock_out  = strobe_q;
  assign link_locked       = locked_q;

endmodule

// ### testbench/tlr_tx_model.sv
// Behavioural serializer that feeds the receiver lanes.
`timescale 1ns/1ps
module tlr_tx_model (
  input  wire logic        link_clk,
  input  wire logic        run,
  input  wire logic [20:0] word,
  output logic      [2:0]  lane,
  output logic             fck
);
  logic [2:0]  slot = 3'h0;
  logic [20:0] w;
  initial begin
    lane = 3'h5;
    fck = 1'b0;
  end
  always @(posedge link_clk) begin
    w = (slot == 3'h0) ? word : w;
    fck <= run && slot < 3'h4;
    // Idle lanes toggle so a stale bit is never mistaken for data.
    for (int l = 0; l < 3; l++) lane[l] <= run ? w[l*7+slot] : ~lane[l];
    slot <= (run && slot < 3'h6) ? slot + 3'h1 : 3'h0;
  end
endmodule

// ### testbench/tlr_receiver_props.sv
// Port checker for the receiver.
`timescale 1ns/1ps
module tlr_receiver_props #(
  parameter int LOCK_CYC = 20,
  parameter int LOSS_CYC = 64
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        forwarded_clock_in,
  input wire logic        sleep_n,
  input wire logic [20:0] parallel_data_out,
  input wire logic        strobe_clock_out,
  input wire logic        link_locked
);
  int   idle_q;
  int   awake_q;
  logic fck_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  always_ff @(posedge mclk) begin
    fck_q <= forwarded_clock_in;
    if (fck_q != forwarded_clock_in) idle_q <= 0;
    else if (idle_q < 1000) idle_q <= idle_q + 1;
  end
  always_ff @(posedge mclk) begin
    if (rst || !sleep_n) awake_q <= 0;
    else if (awake_q <= LOCK_CYC) awake_q <= awake_q + 1;
  end
  a_data_strobe: assert property ($changed(parallel_data_out) && sleep_n &&
    $past(sleep_n) |-> !strobe_clock_out ##1 strobe_clock_out) else $error("strobe vs data");
  a_strobe_high: assert property ($fell(strobe_clock_out) && sleep_n &&
    $past(sleep_n) |=> strobe_clock_out[*8]) else $error("strobe too short");
  a_sleep_freeze: assert property (!sleep_n[*5] |->
    $stable(parallel_data_out) && $stable(strobe_clock_out)) else $error("sleep moved");
  a_sleep_unlock: assert property (!sleep_n[*5] |-> !link_locked)
    else $error("locked asleep");
  a_loss_hold: assert property (idle_q > 16 |->
    $stable(parallel_data_out) && $stable(strobe_clock_out)) else $error("loss moved");
  a_loss_unlock: assert property (idle_q > LOSS_CYC + 8 |-> !link_locked)
    else $error("locked no clock");
  a_lock_wait: assert property ($rose(link_locked) |-> awake_q >= LOCK_CYC)
    else $error("lock early");
  a_update_locked: assert property ($changed(parallel_data_out) |-> link_locked)
    else $error("data unlocked");
  cover property ($rose(link_locked));
  cover property (!sleep_n[*5]);
  cover property (idle_q > LOSS_CYC + 8);
endmodule

bind tlr_receiver tlr_receiver_props #(.LOCK_CYC(LOCK_CYC), .LOSS_CYC(LOSS_CYC))
  tlr_receiver_props_i (.mclk, .rst, .forwarded_clock_in, .sleep_n,
  .parallel_data_out, .strobe_clock_out, .link_locked);

// ### testbench/tlr_receiver_tb.sv
// Self-checking bench for the receiver.
`timescale 1ns/1ps
module tlr_receiver_tb;
  logic        mclk;
  logic        rst;
  logic        link_clk;
  logic        sleep_n;
  logic        tx_run;
  logic [20:0] tx_word;
  logic [2:0]  lanes;
  logic        fck;
  logic [20:0] data;
  logic        strobe;
  logic        locked;
  int          n_fail;
  int          samples_checked;

  tlr_receiver #(.LOCK_CYC(20)) tlr_receiver_i (.mclk(mclk), .rst(rst),
    .link_clk(link_clk), .serial_lane_in(lanes), .forwarded_clock_in(fck),
    .sleep_n(sleep_n), .parallel_data_out(data), .strobe_clock_out(strobe),
    .link_locked(locked));
  tlr_tx_model tlr_tx_model_i (.link_clk(link_clk), .run(tx_run), .word(tx_word),
    .lane(lanes), .fck(fck));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic rises(input int n);
    logic p;
    int   k;
    p = strobe;
    k = 0;
    repeat (400) begin
      @(posedge mclk);
      if (strobe === 1'b1 && p !== 1'b1) k++;
      p = strobe;
      if (k >= n) break;
    end
    chk({20'h0, k >= n}, 21'h1);
  endtask

  task automatic lock_up;
    repeat (300) begin
      @(posedge mclk);
      if (locked === 1'b1) break;
    end
    chk({20'h0, locked}, 21'h1);
  endtask

  // Three rises cover the frame in flight and the one being sent.
  task automatic send(input logic [20:0] w);
    tx_word <= w;
    rises(3);
    chk(data, w);
  endtask

  task automatic t_map;
    logic [20:0] pat [5] = '{21'h000001, 21'h000040, 21'h000080, 21'h100000, 21'h155555};
    foreach (pat[i]) send(pat[i]);
    $display("lane map test done");
  endtask

  task automatic t_sleep;
    send(21'h0abcde);
    sleep_n <= 1'b0;
    tx_word <= 21'h123456;
    repeat (60) @(posedge mclk);
    chk(data, 21'h0abcde);
    chk({20'h0, locked}, 21'h0);
    sleep_n <= 1'b1;
    lock_up;
    send(21'h123456);
    $display("sleep test done");
  endtask

  task automatic t_loss;
    send(21'h054321);
    tx_run <= 1'b0;
    repeat (120) @(posedge mclk);
    chk(data, 21'h054321);
    chk({20'h0, locked}, 21'h0);
    tx_run <= 1'b1;
    lock_up;
    send(21'h1fffff);
    $display("clock loss test done");
  endtask

  initial begin
    rst = 1'b1;
    sleep_n = 1'b1;
    tx_run = 1'b0;
    tx_word = 21'h0;
    n_fail = 0;
    samples_checked = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    tx_run <= 1'b1;
    lock_up;
    t_map;
    t_sleep;
    t_loss;
    stop_test;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    stop_test;
  end
endmodule
